// >>> include/dms_pkg.sv
package dms_pkg;
	// ====================
	// Register map (parallel byte addresses)
	localparam logic [5:0] FIRST_TUNING_ADDR  = 6'h04;
	localparam logic [5:0] SECOND_TUNING_ADDR = 6'h0a;
	localparam logic [5:0] PHASE_OFS_ADDR     = 6'h00;
	localparam logic [5:0] AMPLITUDE_ADDR     = 6'h21;
	localparam logic [5:0] MODE_CONFIG_ADDR   = 6'h1f;
	localparam int         TUNING_BYTES       = 6;
	localparam int         TUNING_W           = 48;
	localparam int         PHASE_W            = 14;
	localparam int         AMPL_W             = 12;
	localparam int         DAC_W              = 12;
	// ====================
	// Mode field layout and reset values
	localparam int         MODE_LSB           = 1;
	localparam int         MODE_W             = 3;
	localparam logic [7:0] MODE_CONFIG_RESET  = 8'h00;
	localparam logic [DAC_W-1:0] DAC_MIDSCALE = 12'h800;
	// ====================
	// Timing of the host programming port
	localparam int         CLK_HZ             = 125_000_000;
	localparam int         PAR_BYTE_HZ        = 100_000_000;
	localparam int         PAR_BYTE_CYC       = (CLK_HZ + PAR_BYTE_HZ - 1) / PAR_BYTE_HZ;
	// ====================
	// Mode encodings
	typedef enum logic [2:0] {
		MODE_SINGLE_TONE = 3'h0,
		MODE_FSK         = 3'h1,
		MODE_RAMPED_FSK  = 3'h2,
		MODE_CHIRP       = 3'h3,
		MODE_BPSK        = 3'h4
	} dms_mode_t;
endpackage : dms_pkg

// >>> include/dms_if.sv
interface dms_if;
	logic       init;
	logic       wr_strobe;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic       keying_select_pin;
	modport device (input init, input wr_strobe, input addr, input wdata, input keying_select_pin);
	modport host   (output init, output wr_strobe, output addr, output wdata,
		output keying_select_pin);
endinterface : dms_if

// >>> logic/dms_host.sv
module dms_host
	import dms_pkg::*;
(
	// Clock and reset
	input  wire logic       REF_CLK_I,
	input  wire logic       RST_N_I,
	input  wire logic       CLK_EN_I,
	// User side
	input  wire logic       INIT_REQ_I,
	input  wire logic       WR_REQ_I,
	input  wire logic [5:0] WR_ADDR_I,
	input  wire logic [7:0] WR_DATA_I,
	input  wire logic       KEY_I,
	output logic            BUSY_O,
	// Link
	dms_if.host             link
);
	logic       init;
	logic       stb;
	logic [5:0] addr;
	logic [7:0] data;
	logic       key;
	logic [1:0] gap;

	assign link.init              = init;
	assign link.wr_strobe         = stb;
	assign link.addr              = addr;
	assign link.wdata             = data;
	assign link.keying_select_pin = key;

	// ====================
	// Byte writes paced to the port rate
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			init   <= 1'b1;
			stb    <= 1'b0;
			addr   <= 6'h00;
			data   <= 8'h00;
			key    <= 1'b0;
			gap    <= 2'h0;
			BUSY_O <= 1'b1;
		end
		else if (CLK_EN_I)
		begin
			key <= KEY_I;
			// (R17) init after power-up
			init   <= INIT_REQ_I;
			stb    <= 1'b0;
			BUSY_O <= INIT_REQ_I;
			if (gap != 2'h0)
			begin
				gap    <= gap - 2'h1;
				BUSY_O <= 1'b1;
			end
			// (R11) host byte writes
			else if (WR_REQ_I && !INIT_REQ_I)
			begin
				stb    <= 1'b1;
				addr   <= WR_ADDR_I;
				data   <= WR_DATA_I;
				gap    <= 2'(PAR_BYTE_CYC);
				BUSY_O <= 1'b1;
			end
		end
	end
endmodule : dms_host

// >>> logic/dms_core.sv
// Overview of operation
// (R1) Mode comes from three bits at 1F
// (R2) Codes 000..100 select five modes
// (R3) Init returns mode to single-tone
// (R4) Single-tone uses first tuning value, reset zero
// (R5) Defaults give 0 Hz, zero phase
// (R6) Zero amplitude drives converters midscale
// (R7) Host computes tuning value from frequency
// (R8) Accumulator never reset on tuning change
// (R9) 14-bit phase offset on cosine path
// (R10) 12-bit amplitude control in single-tone
// (R11) Settings writable while running, byte port
// (R12) FSK pin low first, high second
// (R13) FSK switching phase-continuous, fixed latency
// (R14) Keying pin ignored in single-tone
// (R15) Phase offset disabled in phase-keying mode
// (R16) Host writes registers for user output
// (R17) Init high restores all defaults
// (R18) Keying pin synchronised before use
module dms_core
	import dms_pkg::*;
#(
	parameter int ACC_W = TUNING_W
)
(
	// Clock and reset
	input  wire logic              REF_CLK_I,
	input  wire logic              RST_N_I,
	input  wire logic              CLK_EN_I,
	// Link
	dms_if.device                  link,
	// Converter and status outputs
	output logic [DAC_W-1:0]       COS_DAC_O,
	output logic [DAC_W-1:0]       CTRL_DAC_O,
	output logic [PHASE_W-1:0]     PHASE_O,
	output logic [2:0]             MODE_O,
	output logic                   KEY_SEL_O
);
	logic [TUNING_W-1:0] low_select_freq;
	logic [TUNING_W-1:0] high_select_freq;
	logic [7:0]          mode_config_reg;
	logic [PHASE_W-1:0]  phase_ofs;
	logic [AMPL_W-1:0]   amplitude;
	logic [ACC_W-1:0]    phase_acc;
	logic                key_meta;
	logic                key_sync;
	logic                key_use;

	// ====================
	// Byte lane decode
	function automatic logic [TUNING_W-1:0] put_byte(input logic [TUNING_W-1:0] w,
		input logic [5:0] idx, input logic [7:0] b);
		logic [TUNING_W-1:0] r;
		r = w;
		// Lowest address holds the top byte
		r[8*(TUNING_BYTES-1-int'(idx)) +: 8] = b;
		return r;
	endfunction : put_byte

	wire       in_first  = link.addr >= FIRST_TUNING_ADDR && link.addr < SECOND_TUNING_ADDR;
	wire       in_second = link.addr >= SECOND_TUNING_ADDR
		&& link.addr < SECOND_TUNING_ADDR + 6'(TUNING_BYTES);
	wire [5:0] first_idx  = link.addr - FIRST_TUNING_ADDR;
	wire [5:0] second_idx = link.addr - SECOND_TUNING_ADDR;
	wire       wr         = link.wr_strobe && !link.init;

	// (R1) mode field decode
	wire [2:0] mode_field = mode_config_reg[MODE_LSB +: MODE_W];
	// (R2) undefined codes fall back to single-tone
	wire dms_mode_t mode = (mode_field > 3'(MODE_BPSK)) ? MODE_SINGLE_TONE
		: dms_mode_t'(mode_field);
	// (R14) pin ignored in single-tone
	assign key_use = (mode != MODE_SINGLE_TONE) && key_sync;
	// (R12) pin selects tuning value in FSK
	wire [TUNING_W-1:0] tuning_value = (mode == MODE_FSK && key_use) ? high_select_freq
		: low_select_freq;
	// (R15) no phase offset in phase keying
	wire [PHASE_W-1:0] ofs_use = (mode == MODE_BPSK) ? '0 : phase_ofs;
	// (R9) offset added on cosine path
	wire [PHASE_W-1:0] cos_phase = phase_acc[ACC_W-1 -: PHASE_W] + ofs_use;
	wire [DAC_W-1:0]   cos_code  = (amplitude == '0) ? DAC_MIDSCALE
		: DAC_MIDSCALE + (cos_phase[PHASE_W-1] ? 12'h000 - amplitude[AMPL_W-1:1]
		: {1'b0, amplitude[AMPL_W-1:1]});

	// ====================
	// Register file
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			low_select_freq  <= '0;
			high_select_freq <= '0;
			mode_config_reg  <= MODE_CONFIG_RESET;
			phase_ofs        <= '0;
			amplitude        <= '0;
		end
		else if (CLK_EN_I)
		begin
			// (R17) init restores defaults
			if (link.init)
			begin
				low_select_freq  <= '0;
				high_select_freq <= '0;
				// (R3) default single-tone
				mode_config_reg  <= MODE_CONFIG_RESET;
				phase_ofs        <= '0;
				amplitude        <= '0;
			end
			// (R11) live byte updates
			else if (wr)
			begin
				if (in_first)
					low_select_freq <= put_byte(low_select_freq, first_idx, link.wdata);
				else if (in_second)
					high_select_freq <= put_byte(high_select_freq, second_idx, link.wdata);
				else if (link.addr == MODE_CONFIG_ADDR)
					mode_config_reg <= link.wdata;
				else if (link.addr == PHASE_OFS_ADDR)
					phase_ofs <= {link.wdata[5:0], phase_ofs[7:0]};
				else if (link.addr == PHASE_OFS_ADDR + 6'h01)
					phase_ofs[7:0] <= link.wdata;
				else if (link.addr == AMPLITUDE_ADDR)
					amplitude <= {link.wdata[3:0], amplitude[7:0]};
				else if (link.addr == AMPLITUDE_ADDR + 6'h01)
					// (R10) 12-bit amplitude
					amplitude[7:0] <= link.wdata;
			end
		end
	end

	// ====================
	// Synchroniser and accumulator datapath
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			key_meta   <= 1'b0;
			key_sync   <= 1'b0;
			phase_acc  <= '0;
			COS_DAC_O  <= DAC_MIDSCALE;
			CTRL_DAC_O <= DAC_MIDSCALE;
			PHASE_O    <= '0;
			MODE_O     <= 3'h0;
			KEY_SEL_O  <= 1'b0;
		end
		else if (CLK_EN_I)
		begin
			// (R18) two-stage synchroniser
			key_meta <= link.keying_select_pin;
			key_sync <= key_meta;
			// (R5) init clears phase for 0 Hz
			if (link.init)
				phase_acc <= '0;
			else
				// (R8) continuous on tuning change; (R13) fixed latency
				// (R4) advanced by tuning value
				phase_acc <= phase_acc + ACC_W'(tuning_value);
			// (R6) zero amplitude gives midscale
			COS_DAC_O  <= cos_code;
			CTRL_DAC_O <= (amplitude == '0) ? DAC_MIDSCALE : cos_code;
			PHASE_O    <= cos_phase;
			MODE_O     <= mode;
			KEY_SEL_O  <= key_use;
		end
	end
endmodule : dms_core

// >>> sim/dms_monitor.sv
module dms_monitor (
	input wire logic       REF_CLK_I,
	input wire logic       RST_N_I,
	input wire logic       init,
	input wire logic       wr_strobe,
	input wire logic [5:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       keying_select_pin,
	input wire logic [2:0] mode,
	input wire logic       key_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	// ====
	// Host side of the link
	property p_stb_gap;
		wr_strobe |=> !wr_strobe [*2];
	endproperty
	a_stb_gap: assert property (p_stb_gap)
		else $error("strobe closer than three cycles");
	property p_no_stb_init;
		init |-> !wr_strobe;
	endproperty
	a_no_stb_init: assert property (p_no_stb_init)
		else $error("strobe during init");
	property p_rst_init;
		!$past(RST_N_I) |-> init;
	endproperty
	a_rst_init: assert property (p_rst_init)
		else $error("init low right after reset");
	property p_hold;
		!wr_strobe && $past(RST_N_I) |-> $stable(addr) && $stable(wdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("address or data moved between writes");
	// ====
	// Core outputs
	property p_mode_legal;
		mode <= 3'h4;
	endproperty
	a_mode_legal: assert property (p_mode_legal)
		else $error("decoded mode outside the five defined codes");
	property p_key_single;
		mode == 3'h0 |-> !key_sel;
	endproperty
	a_key_single: assert property (p_key_single)
		else $error("keying select active in single-tone");
	property p_key_sync;
		mode != 3'h0 |-> key_sel == $past(keying_select_pin, 3);
	endproperty
	a_key_sync: assert property (p_key_sync)
		else $error("keying select not three cycles behind the pin");
endmodule : dms_monitor

// >>> sim/testbench.sv
module testbench import dms_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              init_req = 1'b0;
	logic              wr_req = 1'b0;
	logic [5:0]        wr_addr = 6'h00;
	logic [7:0]        wr_data = 8'h00;
	logic              key = 1'b0;
	logic              busy;
	logic              key_sel;
	logic [DAC_W-1:0]  cos_dac;
	logic [DAC_W-1:0]  ctrl_dac;
	logic [PHASE_W-1:0] phase;
	logic [2:0]        mode;
	int                fails = 0;
	int                checks = 0;
	int                cyc = 0;
	dms_if link ();
	always #4 clk = ~clk;
	dms_host dms_host_inst (.REF_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1),
		.INIT_REQ_I(init_req), .WR_REQ_I(wr_req), .WR_ADDR_I(wr_addr),
		.WR_DATA_I(wr_data), .KEY_I(key), .BUSY_O(busy), .link(link));
	dms_core dms_core_inst (.REF_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1),
		.link(link), .COS_DAC_O(cos_dac), .CTRL_DAC_O(ctrl_dac), .PHASE_O(phase),
		.MODE_O(mode), .KEY_SEL_O(key_sel));
	dms_monitor dms_monitor_inst (.REF_CLK_I(clk), .RST_N_I(rst_n), .init(link.init),
		.wr_strobe(link.wr_strobe), .addr(link.addr), .wdata(link.wdata),
		.keying_select_pin(link.keying_select_pin), .mode(mode), .key_sel(key_sel));
	// ====
	// Shared tasks
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic idle();
		do @(negedge clk); while (busy !== 1'b0);
		repeat (2) @(negedge clk);
	endtask : idle
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_req <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_req <= 1'b0;
		idle();
	endtask : wr
	task automatic step(input logic [13:0] exp);
		logic [13:0] p0;
		logic [13:0] d;
		@(negedge clk);
		p0 = phase;
		@(negedge clk);
		d = phase - p0;
		chk("phase step", {2'h0, exp}, {2'h0, d});
	endtask : step
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			tally_and_finish();
		end
	end
	// ====
	// Test sequence
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		idle();
		chk("mode", 16'h0, mode);
		chk("phase", 16'h0, phase);
		chk("cos dac", DAC_MIDSCALE, cos_dac);
		chk("ctrl dac", DAC_MIDSCALE, ctrl_dac);
		wr(PHASE_OFS_ADDR + 6'h01, 8'h10);
		chk("phase offset", 16'h0010, phase);
		wr(MODE_CONFIG_ADDR, 8'h08);
		chk("phase in bpsk", 16'h0, phase);
		$display("Defaults and offset done");
		for (logic [3:0] m = 4'h0; m < 4'h5; m++)
		begin
			wr(MODE_CONFIG_ADDR, {4'h0, m[2:0], 1'b0});
			chk("mode", {12'h0, m}, mode);
		end
		wr(6'h30, 8'h00);
		chk("mode", 16'h4, mode);
		wr(MODE_CONFIG_ADDR, 8'h0a);
		chk("undefined mode", 16'h0, 16'(mode));
		$display("Modes done");
		wr(MODE_CONFIG_ADDR, 8'h00);
		@(posedge clk);
		key <= 1'b1;
		wr(FIRST_TUNING_ADDR + 6'h01, 8'h04);
		step(14'h0001);
		wr(SECOND_TUNING_ADDR + 6'h01, 8'h08);
		step(14'h0001);
		chk("key select", 16'h0, key_sel);
		wr(MODE_CONFIG_ADDR, 8'h02);
		step(14'h0002);
		chk("key select", 16'h1, key_sel);
		@(posedge clk);
		key <= 1'b0;
		repeat (3) @(negedge clk);
		// Pin falls through host stage and two synchroniser stages
		step(14'h0002);
		step(14'h0001);
		wr(AMPLITUDE_ADDR + 6'h01, 8'h40);
		checks++;
		if (cos_dac !== 12'h820 && cos_dac !== 12'h7e0)
		begin
			fails++;
			$display("Error cos dac expected 820 or 7e0 seen %h", cos_dac);
		end
		checks++;
		if (ctrl_dac !== 12'h820 && ctrl_dac !== 12'h7e0)
		begin
			fails++;
			$display("Error ctrl dac expected 820 or 7e0 seen %h", ctrl_dac);
		end
		$display("Tuning and keying done");
		@(posedge clk);
		init_req <= 1'b1;
		@(posedge clk);
		init_req <= 1'b0;
		idle();
		chk("mode", 16'h0, mode);
		step(14'h0000);
		chk("phase", 16'h0, phase);
		$display("Init done");
		wr(PHASE_OFS_ADDR, 8'hff);
		chk("phase offset high", 16'h3f00, 16'(phase));
		wr(AMPLITUDE_ADDR, 8'h0f);
		chk("cos dac", 16'h0080, 16'(cos_dac));
		chk("ctrl dac", 16'h0080, 16'(ctrl_dac));
		$display("Offset and amplitude high bytes done");
		tally_and_finish();
	end
endmodule : testbench
